/* rtl/wrc_regs.vh */
// register map, field positions, reset values and timing counts of the supervisor block
`ifndef WRC_REGS_VH
`define WRC_REGS_VH

// register indices; byte address inside the window is four times the index
`define WRC_IDX_PERIODIC_IRQ_CONTROL 7'h14
`define WRC_IDX_PERIODIC_IRQ_FLAG    7'h15
`define WRC_IDX_SUPERVISOR_CONTROL   7'h16
`define WRC_IDX_WATCHDOG_SERVICE     7'h17
`define WRC_IDX_WINDOW_BASE          7'h18

// reset values
`define WRC_RST_PERIODIC_IRQ_CONTROL 8'h00
`define WRC_RST_PERIODIC_IRQ_FLAG    8'h00
`define WRC_RST_SUPERVISOR_CONTROL   8'h00
`define WRC_RST_WINDOW_BASE          5'h00

// periodic_irq_control fields
`define WRC_PIC_ENABLE_BIT    7
`define WRC_PIC_WAIT_STOP_BIT 6
`define WRC_PIC_BGND_STOP_BIT 5
`define WRC_PIC_BYPASS_BIT    3
`define WRC_PIC_RATE_MSB      2
`define WRC_PIC_RATE_LSB      0

// periodic_irq_flag field
`define WRC_PIF_FLAG_BIT 7

// supervisor_control fields
`define WRC_SC_MON_EN_BIT     7
`define WRC_SC_FORCE_MON_BIT  6
`define WRC_SC_FORCE_MRST_BIT 5
`define WRC_SC_FORCE_WRST_BIT 4
`define WRC_SC_RST_DIS_BIT    3
`define WRC_SC_RATE_MSB       2
`define WRC_SC_RATE_LSB       0

// watchdog service keys
`define WRC_KEY_FIRST  8'h55
`define WRC_KEY_SECOND 8'haa

// address window: 2-Kbyte boundary, block in the first 512 bytes
`define WRC_WIN_BASE_MSB 15
`define WRC_WIN_BASE_LSB 11
`define WRC_WIN_SUB_MSB  10
`define WRC_WIN_SUB_LSB  9

// prescale chain: normal base 2^13, bypassed base 4 (terminal counts)
`define WRC_BASE_LAST   13'h1fff
`define WRC_BYPASS_LAST 13'h0003

`endif

/* rtl/wrc_prescale.v */
// prescale chain plus rate tap: one tick every base * 2^shift enabled cycles
`timescale 1ns/1ps
module wrc_prescale #(
   parameter POST_W = 11
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              run,
   input  wire              restart,
   input  wire              bypass,
   input  wire [3:0]        shift,
   output reg               tick_q
);
`include "wrc_regs.vh"

   reg  [12:0]       base_q;
   reg  [POST_W-1:0] post_q;
   wire [12:0]       base_last;
   wire              base_tick;
   wire [POST_W-1:0] post_mask;

   // base divider terminal count chosen by bypass
   assign base_last = bypass ? `WRC_BYPASS_LAST : `WRC_BASE_LAST; // R13
   assign base_tick = run && (base_q >= base_last);
   assign post_mask = ({POST_W{1'b1}} >> (POST_W[3:0] - shift));

   // base and post counters; restart clears both
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_q <= 13'h0000;
         post_q <= {POST_W{1'b0}};
         tick_q <= 1'b0;
      end else if (restart) begin
         base_q <= 13'h0000;
         post_q <= {POST_W{1'b0}};
         tick_q <= 1'b0;
      end else begin
         tick_q <= base_tick && ((post_q & post_mask) == post_mask);
         if (base_tick) begin
            base_q <= 13'h0000;
            post_q <= post_q + {{(POST_W-1){1'b0}}, 1'b1};
         end else if (run) begin
            base_q <= base_q + 13'h0001;
         end
      end
   end

endmodule // wrc_prescale

/* rtl/wrc_clk_monitor.v */
// clock monitor: synchronises the self-timed detector and forms the failure level
`timescale 1ns/1ps
module wrc_clk_monitor (
   input  wire pclk,
   input  wire presetn,
   input  wire clock_slow,
   input  wire stop_mode,
   input  wire mon_active,
   output reg  fail_q
);

   reg slow_s1_q;
   reg slow_s2_q;

   // two-stage synchroniser for the detector pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_s1_q <= 1'b0;
         slow_s2_q <= 1'b0;
      end else begin
         slow_s1_q <= clock_slow;
         slow_s2_q <= slow_s1_q;
      end
   end

   // slow, stopped or stop-mode entry counts as failure while active
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= mon_active && (slow_s2_q || stop_mode); // R14 R15
      end
   end

endmodule // wrc_clk_monitor

/* rtl/wrc_supervisor.v */
// watchdog, periodic interrupt and clock monitor with APB register access
//
// Contract
// R1 - software writes first key then second key within the watchdog period
// R2 - watchdog period expiry without completed key pair forces system reset
// R3 - writing any non-key value to the service register forces reset
// R4 - three-bit watchdog rate field: seven periods plus off
// R5 - watchdog codes 001..111 divide by 2^13,15,17,19,21,22,23; 000 off
// R6 - other register accesses between the two keys keep the sequence
// R7 - periodic rate 001..111 divides by 2^13..2^19; writable anytime
// R8 - periodic flag sets each time the selected period elapses
// R9 - periodic request raised only while flag and enable are both set
// R10 - writing one clears the flag, zero keeps it, other bits read zero
// R11 - wait-stop bit halts periodic and watchdog in wait mode; write once
// R12 - background-stop bit halts both in background mode; write once
// R13 - bypass makes the base divide by 4; special modes only
// R14 - self-timed monitor detects missing clocks and can start reset
// R15 - monitor enable makes slow or stopped clocks, stop entry, reset
// R16 - force-monitor keeps monitor on until reset, enable ignored
// R17 - force-monitor-reset test bit forces reset on detected failure
// R18 - reset-disable makes the force-monitor-reset bit ineffective
// R19 - reset-disable suppresses monitor and watchdog resets
// R20 - software clears monitor enable before stop and sets it after
// R21 - register block relocates to 2-Kbyte boundaries, first 512 bytes
// R22 - write-once bits lock after first write in normal modes
`timescale 1ns/1ps
module wrc_supervisor (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire        special_mode,
   input  wire        wait_mode,
   input  wire        bgnd_mode,
   input  wire        stop_mode,
   input  wire        clock_slow,
   output wire        periodic_irq,
   output reg         watchdog_reset_q,
   output reg         monitor_reset_q
);
`include "wrc_regs.vh"

   // watchdog service states
   localparam [0:0] SVC_IDLE  = 1'b0;
   localparam [0:0] SVC_ARMED = 1'b1;

   reg  [7:0]  pic_q;
   reg         flag_q;
   reg  [7:0]  sc_q;
   reg  [4:0]  win_base_q;
   reg         lock_wait_q;
   reg         lock_bgnd_q;
   reg         lock_force_mon_q;
   reg         lock_wd_rate_q;
   reg  [0:0]  svc_q;
   reg  [0:0]  svc_d;
   reg         svc_done;
   reg         svc_bad;
   reg  [3:0]  wd_shift;
   reg  [7:0]  rd_data;
   reg         hit;

   wire        in_window;
   wire [6:0]  idx;
   wire        setup;
   wire        access;
   wire        wr;
   wire [7:0]  wb;
   wire        halt;
   wire        pi_run;
   wire        wd_enabled;
   wire        wd_run;
   wire        pi_tick;
   wire        wd_tick;
   wire [3:0]  pi_shift;
   wire        mon_active;
   wire        mon_fail;
   wire        wr_pic;
   wire        wr_flag;
   wire        wr_sc;
   wire        wr_svc;
   wire        wr_win;

   // address decode inside the relocatable window
   assign in_window = (paddr[`WRC_WIN_BASE_MSB:`WRC_WIN_BASE_LSB] == win_base_q) &&
                      (paddr[`WRC_WIN_SUB_MSB:`WRC_WIN_SUB_LSB] == 2'b00); // R21
   assign idx       = paddr[8:2];
   assign setup     = psel && !penable;
   assign access    = psel && penable;
   assign wr        = access && pwrite && hit;
   assign wb        = pwdata[7:0];
   assign wr_pic    = wr && (idx == `WRC_IDX_PERIODIC_IRQ_CONTROL);
   assign wr_flag   = wr && (idx == `WRC_IDX_PERIODIC_IRQ_FLAG);
   assign wr_sc     = wr && (idx == `WRC_IDX_SUPERVISOR_CONTROL);
   assign wr_svc    = wr && (idx == `WRC_IDX_WATCHDOG_SERVICE);
   assign wr_win    = wr && (idx == `WRC_IDX_WINDOW_BASE);

   // no wait states: data captured in setup, answered in the first access cycle
   assign pready  = access;
   assign pslverr = access && !hit;

   // register hit and read mux
   always @* begin
      hit     = 1'b0;
      rd_data = 8'h00;
      if (!in_window || (paddr[1:0] != 2'b00)) begin
         hit     = 1'b0;
         rd_data = 8'h00;
      end else if (idx == `WRC_IDX_PERIODIC_IRQ_CONTROL) begin
         hit     = 1'b1;
         rd_data = pic_q;
      end else if (idx == `WRC_IDX_PERIODIC_IRQ_FLAG) begin
         hit     = 1'b1;
         rd_data = {flag_q, 7'h00}; // R10
      end else if (idx == `WRC_IDX_SUPERVISOR_CONTROL) begin
         hit     = 1'b1;
         rd_data = sc_q;
      end else if (idx == `WRC_IDX_WATCHDOG_SERVICE) begin
         hit     = 1'b1;
         rd_data = 8'h00;
      end else if (idx == `WRC_IDX_WINDOW_BASE) begin
         hit     = 1'b1;
         rd_data = {3'b000, win_base_q};
      end
   end

   // read data register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {24'h00_0000, rd_data};
      end
   end

   // periodic control register with per-bit write permission
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pic_q       <= `WRC_RST_PERIODIC_IRQ_CONTROL;
         lock_wait_q <= 1'b0;
         lock_bgnd_q <= 1'b0;
      end else if (wr_pic) begin
         pic_q[`WRC_PIC_ENABLE_BIT] <= wb[`WRC_PIC_ENABLE_BIT]; // R9
         pic_q[`WRC_PIC_RATE_MSB:`WRC_PIC_RATE_LSB] <=
            wb[`WRC_PIC_RATE_MSB:`WRC_PIC_RATE_LSB]; // R7
         if (special_mode || !lock_wait_q) begin
            pic_q[`WRC_PIC_WAIT_STOP_BIT] <= wb[`WRC_PIC_WAIT_STOP_BIT]; // R11
         end
         if (special_mode || !lock_bgnd_q) begin
            pic_q[`WRC_PIC_BGND_STOP_BIT] <= wb[`WRC_PIC_BGND_STOP_BIT]; // R12
         end
         if (special_mode) begin
            pic_q[`WRC_PIC_BYPASS_BIT] <= wb[`WRC_PIC_BYPASS_BIT]; // R13
         end
         if (!special_mode) begin
            lock_wait_q <= 1'b1; // R22
            lock_bgnd_q <= 1'b1; // R22
         end
      end
   end

   // supervisor control register with per-bit write permission
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_q             <= `WRC_RST_SUPERVISOR_CONTROL;
         lock_force_mon_q <= 1'b0;
         lock_wd_rate_q   <= 1'b0;
      end else if (wr_sc) begin
         sc_q[`WRC_SC_MON_EN_BIT] <= wb[`WRC_SC_MON_EN_BIT]; // R15
         if (special_mode || !lock_force_mon_q) begin
            sc_q[`WRC_SC_FORCE_MON_BIT] <= wb[`WRC_SC_FORCE_MON_BIT]; // R16
         end
         if (special_mode || !lock_wd_rate_q) begin
            sc_q[`WRC_SC_RATE_MSB:`WRC_SC_RATE_LSB] <=
               wb[`WRC_SC_RATE_MSB:`WRC_SC_RATE_LSB]; // R4
         end
         if (special_mode) begin
            sc_q[`WRC_SC_FORCE_MRST_BIT] <= wb[`WRC_SC_FORCE_MRST_BIT]; // R17
            sc_q[`WRC_SC_FORCE_WRST_BIT] <= wb[`WRC_SC_FORCE_WRST_BIT];
            sc_q[`WRC_SC_RST_DIS_BIT]    <= wb[`WRC_SC_RST_DIS_BIT];
         end
         if (!special_mode) begin
            lock_force_mon_q <= 1'b1; // R22
            lock_wd_rate_q   <= 1'b1; // R22
         end
      end
   end

   // window base register, writable anytime
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_base_q <= `WRC_RST_WINDOW_BASE;
      end else if (wr_win) begin
         win_base_q <= wb[4:0]; // R21
      end
   end

   // halting conditions shared by periodic timer and watchdog
   assign halt   = stop_mode ||
                   (wait_mode && pic_q[`WRC_PIC_WAIT_STOP_BIT]) || // R11
                   (bgnd_mode && pic_q[`WRC_PIC_BGND_STOP_BIT]); // R12
   assign pi_run = !halt && (pic_q[`WRC_PIC_RATE_MSB:`WRC_PIC_RATE_LSB] != 3'b000);
   assign pi_shift = {1'b0, pic_q[`WRC_PIC_RATE_MSB:`WRC_PIC_RATE_LSB] - 3'b001}; // R7

   // periodic interrupt chain
   wrc_prescale #(
      .POST_W (11)
   ) u_pi_chain (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (pi_run),
      .restart (1'b0),
      .bypass  (pic_q[`WRC_PIC_BYPASS_BIT]),
      .shift   (pi_shift),
      .tick_q  (pi_tick)
   );

   // periodic flag: set wins over a same-cycle clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (pi_tick) begin
         flag_q <= 1'b1; // R8
      end else if (wr_flag && wb[`WRC_PIF_FLAG_BIT]) begin
         flag_q <= 1'b0; // R10
      end
   end

   assign periodic_irq = flag_q && pic_q[`WRC_PIC_ENABLE_BIT]; // R9

   // watchdog rate code to divider shift beyond the 2^13 base
   always @* begin
      case (sc_q[`WRC_SC_RATE_MSB:`WRC_SC_RATE_LSB]) // R5
         3'b001:  wd_shift = 4'h0;
         3'b010:  wd_shift = 4'h2;
         3'b011:  wd_shift = 4'h4;
         3'b100:  wd_shift = 4'h6;
         3'b101:  wd_shift = 4'h8;
         3'b110:  wd_shift = 4'h9;
         3'b111:  wd_shift = 4'ha;
         default: wd_shift = 4'h0;
      endcase
   end

   assign wd_enabled = (sc_q[`WRC_SC_RATE_MSB:`WRC_SC_RATE_LSB] != 3'b000); // R4
   assign wd_run     = wd_enabled && !halt;

   // service sequence; other accesses do not disturb it
   always @* begin
      svc_d    = svc_q;
      svc_done = 1'b0;
      svc_bad  = 1'b0;
      if (wr_svc && wd_enabled) begin // R6
         if (wb == `WRC_KEY_FIRST) begin
            svc_d = SVC_ARMED; // R1
         end else if (wb == `WRC_KEY_SECOND) begin
            case (svc_q)
               SVC_ARMED: begin
                  svc_d    = SVC_IDLE;
                  svc_done = 1'b1; // R1
               end
               default: begin
                  svc_d = SVC_IDLE;
               end
            endcase
         end else begin
            svc_bad = 1'b1; // R3
            svc_d   = SVC_IDLE;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_q <= SVC_IDLE;
      end else begin
         svc_q <= svc_d;
      end
   end

   // watchdog timeout chain, restarted by a completed key pair or when off
   wrc_prescale #(
      .POST_W (11)
   ) u_wd_chain (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (wd_run),
      .restart (svc_done || !wd_enabled),
      .bypass  (pic_q[`WRC_PIC_BYPASS_BIT]),
      .shift   (wd_shift),
      .tick_q  (wd_tick)
   );

   // clock monitor active when enabled, forced, or under test force
   assign mon_active = sc_q[`WRC_SC_FORCE_MON_BIT] || sc_q[`WRC_SC_MON_EN_BIT] || // R16
                       (sc_q[`WRC_SC_FORCE_MRST_BIT] && !sc_q[`WRC_SC_RST_DIS_BIT]); // R17 R18

   wrc_clk_monitor u_monitor (
      .pclk       (pclk),
      .presetn    (presetn),
      .clock_slow (clock_slow),
      .stop_mode  (stop_mode),
      .mon_active (mon_active),
      .fail_q     (mon_fail)
   );

   // reset requests, both suppressed by reset-disable; held until system reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_reset_q <= 1'b0;
         monitor_reset_q  <= 1'b0;
      end else begin
         if (!sc_q[`WRC_SC_RST_DIS_BIT] &&
             (wd_tick || svc_bad ||
              (wd_enabled && sc_q[`WRC_SC_FORCE_WRST_BIT]))) begin // R2 R3 R19
            watchdog_reset_q <= 1'b1;
         end
         if (!sc_q[`WRC_SC_RST_DIS_BIT] && mon_fail) begin // R14 R15 R19
            monitor_reset_q <= 1'b1;
         end
      end
   end

endmodule // wrc_supervisor

/* sim/wrc_supervisor_assertions.sv */
// assertion checker for the supervisor block
`timescale 1ns/1ps
module wrc_sva (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   input wire        special_mode,
   input wire        wait_mode,
   input wire        bgnd_mode,
   input wire        stop_mode,
   input wire        clock_slow,
   input wire        periodic_irq,
   input wire        watchdog_reset_q,
   input wire        monitor_reset_q
);
   reg  wd_arm_q;
   reg  mon_arm_q;
   reg  dis_q;
   wire wr_go = psel & penable & pwrite;
   wire sc_wr = wr_go & (paddr == 16'h0058);

   // shadow of special-mode supervisor_control writes, cleared when unsure
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_arm_q <= 1'b0;
         mon_arm_q <= 1'b0;
         dis_q <= 1'b0;
      end else if (sc_wr & special_mode) begin
         wd_arm_q <= (pwdata[2:0] != 3'h0) & ~pwdata[3];
         mon_arm_q <= pwdata[7] & ~pwdata[3];
         dis_q <= pwdata[3];
      end else if (sc_wr | (wr_go & (paddr == 16'h0060))) begin
         wd_arm_q <= 1'b0;
         mon_arm_q <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   err_outside_block_a: assert property (psel && penable && paddr[10:9] != 2'h0 |-> pslverr)
      else $error("no error outside the block window");
   err_only_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   rdata_hold_a: assert property (psel && penable |=> $stable(prdata))
      else $error("read data moved right after access phase");
   flag_read_zero_a: assert property (psel && penable && !pwrite && paddr == 16'h0054
      |-> prdata[6:0] == 7'h00)
      else $error("flag register spare bits not zero");
   svc_read_zero_a: assert property (psel && penable && !pwrite && paddr == 16'h005c
      |-> prdata == 32'h0)
      else $error("service register read not zero");
   irq_fall_cause_a: assert property ($fell(periodic_irq) |-> $past(wr_go))
      else $error("periodic request dropped without a write");
   bad_key_reset_a: assert property (wd_arm_q && wr_go && paddr == 16'h005c
      && pwdata[7:0] != 8'h55 && pwdata[7:0] != 8'haa |-> ##[1:2] watchdog_reset_q)
      else $error("bad key gave no watchdog reset");
   wd_sticky_a: assert property (watchdog_reset_q |=> watchdog_reset_q)
      else $error("watchdog reset released early");
   mon_slow_reset_a: assert property (mon_arm_q && clock_slow |-> ##[1:6] monitor_reset_q)
      else $error("slow clock gave no monitor reset");
   mon_sticky_a: assert property (monitor_reset_q |=> monitor_reset_q)
      else $error("monitor reset released early");
   disabled_quiet_a: assert property (dis_q && !watchdog_reset_q && !monitor_reset_q
      |=> !watchdog_reset_q && !monitor_reset_q)
      else $error("reset raised while disabled");
endmodule // wrc_sva

bind wrc_supervisor wrc_sva i_wrc_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .special_mode(special_mode), .wait_mode(wait_mode),
   .bgnd_mode(bgnd_mode), .stop_mode(stop_mode), .clock_slow(clock_slow),
   .periodic_irq(periodic_irq), .watchdog_reset_q(watchdog_reset_q),
   .monitor_reset_q(monitor_reset_q));

/* sim/wrc_supervisor_tb.sv */
// self-checking bench for the supervisor block
`timescale 1ns/1ps
module wrc_supervisor_tb;
   reg         pclk, presetn, psel, penable, pwrite, special_mode;
   reg         wait_mode, bgnd_mode, stop_mode, clock_slow;
   reg  [15:0] paddr;
   reg  [31:0] pwdata;
   reg  [31:0] rdv;
   reg         erv;
   wire        pready, pslverr, periodic_irq, watchdog_reset_q, monitor_reset_q;
   wire [31:0] prdata;
   integer     fail_count, n_compared, cyc, r, n, t1, v;
   // monitor cases {expected reset, control value}, entries 6 and 7 use stop
   localparam [71:0] MT = {9'h000, 9'h180, 9'h180, 9'h000, 9'h140, 9'h120, 9'h088, 9'h0a8};

   wrc_supervisor i_wrc_supervisor (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .special_mode(special_mode), .wait_mode(wait_mode),
      .bgnd_mode(bgnd_mode), .stop_mode(stop_mode), .clock_slow(clock_slow),
      .periodic_irq(periodic_irq), .watchdog_reset_q(watchdog_reset_q),
      .monitor_reset_q(monitor_reset_q));

   // clock and cycle count
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task stop_test;
      begin
         if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   task rst;
      begin
         presetn <= 1'b0;
         clock_slow <= 1'b0;
         stop_mode <= 1'b0;
         repeat (3) @(posedge pclk);
         presetn <= 1'b1;
      end
   endtask

   // one bus transfer, request held until pready is sampled high
   task apb(input w, input [15:0] a, input [7:0] d);
      integer k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         do begin
            @(posedge pclk);
            k = k + 1;
         end while (pready !== 1'b1 && k < 20);
         if (k >= 20) begin
            fail_count = fail_count + 1;
            stop_test;
         end
         rdv = prdata;
         erv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task rd(input [15:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 8'h00);
         chk(rdv, e);
      end
   endtask

   // wait up to lim cycles for irq (0), watchdog (1) or monitor (2); n = -1 if never
   task wt(input integer s, input integer lim);
      integer k;
      begin
         n = -1;
         for (k = 1; k <= lim && n < 0; k = k + 1) begin
            @(posedge pclk);
            #1;
            if ((s == 0 ? periodic_irq : s == 1 ? watchdog_reset_q : monitor_reset_q) === 1'b1)
               n = k;
         end
      end
   endtask

   initial begin
      {presetn, psel, penable, pwrite, special_mode} = 5'h0;
      {wait_mode, bgnd_mode, stop_mode, clock_slow} = 4'h0;
      paddr = 16'h0;
      pwdata = 32'h0;
      fail_count = 0;
      n_compared = 0;
      cyc = 0;
      v = $urandom(32'he5582e39);
      rst;
      // reset values and an address outside the block
      rd(16'h0050, 32'h0);
      rd(16'h0054, 32'h0);
      rd(16'h0058, 32'h0);
      rd(16'h005c, 32'h0);
      rd(16'h0250, 32'h0);
      chk(erv, 1'b1);
      // normal mode: bypass refused, wait-stop locks after first write
      apb(1'b1, 16'h0050, 8'h48);
      rd(16'h0050, 32'h40);
      apb(1'b1, 16'h0050, 8'h07);
      rd(16'h0050, 32'h47);
      // normal mode: test and disable bits refused, write-once control bits lock
      apb(1'b1, 16'h0058, 8'hb9);
      rd(16'h0058, 32'h81);
      apb(1'b1, 16'h0058, 8'h42);
      rd(16'h0058, 32'h01);
      rst;
      special_mode <= 1'b1;
      // periodic rates, measured between two flag sets
      for (r = 2; r <= 7; r = r + 1) begin
         apb(1'b1, 16'h0050, 8'h88 | r);
         apb(1'b1, 16'h0054, 8'h80);
         wt(0, 600);
         t1 = cyc;
         apb(1'b1, 16'h0054, 8'h80);
         #1;
         chk(periodic_irq, 1'b0);
         wt(0, 600);
         chk(cyc - t1, 4 << (r - 1));
      end
      chk(watchdog_reset_q, 1'b0);
      // enable gating and zero write to the flag
      apb(1'b1, 16'h0050, 8'h09);
      wt(0, 20);
      chk(n, -1);
      rd(16'h0054, 32'h80);
      apb(1'b1, 16'h0054, 8'h00);
      rd(16'h0054, 32'h80);
      apb(1'b1, 16'h0050, 8'h89);
      #1;
      chk(periodic_irq, 1'b1);
      // halting in wait and background modes
      for (r = 0; r < 2; r = r + 1) begin
         apb(1'b1, 16'h0050, 8'hea);
         if (r == 0) wait_mode <= 1'b1;
         else bgnd_mode <= 1'b1;
         apb(1'b1, 16'h0054, 8'h80);
         wt(0, 40);
         chk(n, -1);
         wait_mode <= 1'b0;
         bgnd_mode <= 1'b0;
         wt(0, 20);
         chk(n > 0, 1'b1);
      end
      // watchdog timeout for every rate code
      for (r = 1; r <= 7; r = r + 1) begin
         rst;
         apb(1'b1, 16'h0050, 8'h08);
         apb(1'b1, 16'h0058, r);
         t1 = cyc;
         wt(1, 5000);
         v = 4 << (r < 6 ? 2 * r - 2 : r + 3);
         chk(cyc - t1 + 8 >= v && cyc - t1 <= v + 4, 1'b1);
      end
      // servicing with other accesses between the keys, then a bad key
      rst;
      apb(1'b1, 16'h0050, 8'h08);
      apb(1'b1, 16'h0058, 8'h03);
      repeat (4) begin
         repeat ($urandom % 16 + 8) @(posedge pclk);
         apb(1'b1, 16'h005c, 8'h55);
         rd(16'h0050, 32'h08);
         apb(1'b1, 16'h005c, 8'haa);
      end
      chk(watchdog_reset_q, 1'b0);
      do v = $urandom % 256; while (v == 8'h55 || v == 8'haa);
      apb(1'b1, 16'h005c, v);
      wt(1, 4);
      chk(n > 0, 1'b1);
      // reset-disable holds the watchdog back
      rst;
      apb(1'b1, 16'h0050, 8'h08);
      apb(1'b1, 16'h0058, 8'h19);
      wt(1, 40);
      chk(n, -1);
      // clock monitor cases
      for (r = 0; r < 8; r = r + 1) begin
         rst;
         apb(1'b1, 16'h0058, MT[r*9 +: 8]);
         if (r >= 6) stop_mode <= 1'b1;
         else clock_slow <= 1'b1;
         wt(2, 8);
         chk(n > 0, MT[r*9+8]);
      end
      // relocation of the register window
      rst;
      apb(1'b1, 16'h0060, 8'h01);
      apb(1'b1, 16'h0850, 8'h05);
      rd(16'h0850, 32'h05);
      rd(16'h0050, 32'h0);
      chk(erv, 1'b1);
      stop_test;
   end
endmodule // wrc_supervisor_tb
